/* File: lfomc_defs.vh */
`ifndef LFOMC_DEFS_VH
`define LFOMC_DEFS_VH
// Parameter slot index inside one LFO's patch block
`define LFOMC_P_SLEW 4'h0
`define LFOMC_P_ENV3 4'h1
`define LFOMC_P_WHEEL 4'h2
`define LFOMC_P_PRESS 4'h3
`define LFOMC_P_RSYNC 4'h4
`define LFOMC_P_DMODE 4'h5
`define LFOMC_P_DDIR 4'h6
`define LFOMC_P_DSYNC 4'h7
`define LFOMC_P_DTRIG 4'h8
`define LFOMC_P_KSYNC 4'h9
`define LFOMC_P_SPEED 4'hA
`define LFOMC_P_DELAY 4'hB
`define LFOMC_P_OFFSET 4'hC
`define LFOMC_P_WAVE 4'hD
`define LFOMC_NPAR 4'hE
// Slots per LFO in the store
`define LFOMC_SLOTS 16
// Number of clock divisions after Off
`define LFOMC_NDIV 8'h22
// Reset values
`define LFOMC_RST_SPEED 8'h40
`define LFOMC_RST_OTHER 8'h00
`define LFOMC_LFSR_SEED 16'hACE1
// Full modulation depth
`define LFOMC_FULL_DEPTH 9'h100
// Slew step base, step is this minus the slew amount
`define LFOMC_SLEW_BASE 11'h080
// Speed clamp upper limit
`define LFOMC_SPEED_MAX 7'h7F
// Waveform codes
`define LFOMC_W_TRI 2'h0
`define LFOMC_W_SAW 2'h1
`define LFOMC_W_SQR 2'h2
`define LFOMC_W_SH 2'h3
`endif

/* File: lfomc_core.v */
`timescale 1ns/1ps
`include "lfomc_defs.vh"
module lfomc_core (
	// Clock and reset
	input wire clk_sys_in,
	input wire rst_in,
	// Timing
	input wire sample_tick_in,
	input wire wrap_in,
	// Oscillator state and settings
	input wire [7:0] phase_in,
	input wire [1:0] wave_in,
	input wire [8:0] depth_in,
	input wire [6:0] slew_in,
	input wire [6:0] offset_in,
	// Result
	output reg signed [9:0] lfo_out
);
	reg [15:0] lfsr_reg;
	reg [7:0] held_reg;
	reg signed [7:0] wave_s;
	wire [7:0] tri_u;
	wire signed [17:0] scaled;
	wire signed [10:0] target;
	wire signed [10:0] diff;
	wire signed [10:0] step;

	// Noise source and held random level
	always @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			lfsr_reg <= `LFOMC_LFSR_SEED;
			held_reg <= 8'h00;
		end else begin
			lfsr_reg <= {lfsr_reg[14:0], lfsr_reg[15] ^ lfsr_reg[13] ^ lfsr_reg[12] ^ lfsr_reg[10]};
			if (wrap_in) begin
				held_reg <= lfsr_reg[7:0];
			end
		end
	end

	// Waveform selection, signed around zero
	assign tri_u = phase_in[7] ? ~{phase_in[6:0], 1'b0} : {phase_in[6:0], 1'b0};
	always @* begin
		case (wave_in)
			`LFOMC_W_TRI: wave_s = $signed(tri_u ^ 8'h80);
			`LFOMC_W_SAW: wave_s = $signed(~phase_in ^ 8'h80);
			`LFOMC_W_SQR: wave_s = phase_in[7] ? $signed(8'h80) : $signed(8'h7F);
			default: wave_s = $signed(held_reg ^ 8'h80);
		endcase
	end

	// Depth scaling, then offset shift
	assign scaled = wave_s * $signed({1'b0, depth_in});
	assign target = $signed(scaled[18-1:8]) + $signed({4'h0, offset_in}) +
		$signed({10'h000, offset_in[6]});
	assign diff = target - $signed({lfo_out[9], lfo_out});
	assign step = `LFOMC_SLEW_BASE - {4'h0, slew_in};

	// Output with slew limit
	always @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			lfo_out <= 10'h000;
		end else if (sample_tick_in) begin
			if (slew_in == 7'h00) begin
				lfo_out <= target[9:0];
			end else if (diff > step) begin
				lfo_out <= lfo_out + step[9:0];
			end else if (diff < -step) begin
				lfo_out <= lfo_out - step[9:0];
			end else begin
				lfo_out <= target[9:0];
			end
		end
	end
endmodule // lfomc_core

/* File: lfomc_top.v */
`timescale 1ns/1ps
`include "lfomc_defs.vh"
module lfomc_top #(
	parameter INC_SHIFT = 10,
	parameter [11:0] DLY_UNIT = 12'h040
) (
	// Clock and reset
	input wire clk_sys_in,
	input wire rst_in,
	// Engine timing
	input wire sample_tick_in,
	input wire midi_tick_in,
	// Key events
	input wire key_on_in,
	input wire key_off_in,
	// Controllers
	input wire [6:0] env3_level_in,
	input wire [6:0] wheel_in,
	input wire [6:0] pressure_in,
	// Front panel edit of selected LFO
	input wire lfo_sel_in,
	input wire edit_we_in,
	input wire [3:0] edit_addr_in,
	input wire [7:0] edit_data_in,
	// Patch load and dump
	input wire patch_we_in,
	input wire patch_lfo_in,
	input wire [3:0] patch_addr_in,
	input wire [7:0] patch_data_in,
	input wire patch_rd_lfo_in,
	input wire [3:0] patch_rd_addr_in,
	output reg [7:0] patch_rd_data_out,
	// Status
	output wire [6:0] held_keys_out,
	output wire [1:0] delay_busy_out,
	output wire [13:0] speed_out,
	// Modulation outputs
	output wire signed [9:0] lfo1_out,
	output wire signed [9:0] lfo2_out
);
	integer i;
	reg [7:0] par_mem [0:2*`LFOMC_SLOTS-1];
	reg [6:0] held_reg;
	wire restart_any;
	wire restart_first;
	wire [19:0] lfo_all;

	// Clock ticks for each division, 24 per quarter note
	function [10:0] lfomc_ticks;
		input [7:0] d;
		begin
			case (d)
				8'h01: lfomc_ticks = 11'h002;
				8'h02: lfomc_ticks = 11'h003;
				8'h03: lfomc_ticks = 11'h004;
				8'h04: lfomc_ticks = 11'h006;
				8'h05: lfomc_ticks = 11'h008;
				8'h06: lfomc_ticks = 11'h009;
				8'h07: lfomc_ticks = 11'h00C;
				8'h08: lfomc_ticks = 11'h010;
				8'h09: lfomc_ticks = 11'h012;
				8'h0A: lfomc_ticks = 11'h018;
				8'h0B: lfomc_ticks = 11'h020;
				8'h0C: lfomc_ticks = 11'h024;
				8'h0D: lfomc_ticks = 11'h030;
				8'h0E: lfomc_ticks = 11'h040;
				8'h0F: lfomc_ticks = 11'h048;
				8'h10: lfomc_ticks = 11'h060;
				8'h11: lfomc_ticks = 11'h080;
				8'h12: lfomc_ticks = 11'h090;
				8'h13: lfomc_ticks = 11'h0C0;
				8'h14: lfomc_ticks = 11'h100;
				8'h15: lfomc_ticks = 11'h120;
				8'h16: lfomc_ticks = 11'h140;
				8'h17: lfomc_ticks = 11'h180;
				8'h18: lfomc_ticks = 11'h1B0;
				8'h19: lfomc_ticks = 11'h1C0;
				8'h1A: lfomc_ticks = 11'h1E0;
				8'h1B: lfomc_ticks = 11'h200;
				8'h1C: lfomc_ticks = 11'h240;
				8'h1D: lfomc_ticks = 11'h2A0;
				8'h1E: lfomc_ticks = 11'h2D0;
				8'h1F: lfomc_ticks = 11'h300;
				8'h20: lfomc_ticks = 11'h360;
				8'h21: lfomc_ticks = 11'h3F0;
				8'h22: lfomc_ticks = 11'h480;
				default: lfomc_ticks = 11'h001;
			endcase
		end
	endfunction

	// Signed depth times controller, scaled to about +-254
	function signed [10:0] lfomc_mod;
		input [7:0] d;
		input [6:0] c;
		reg signed [15:0] p;
		reg signed [15:0] q;
		begin
			p = $signed(d) * $signed({1'b0, c});
			q = p >>> 6;
			lfomc_mod = q[10:0];
		end
	endfunction

	// Reset value of one store slot
	function [7:0] lfomc_rst_val;
		input [3:0] a;
		begin
			if (a == `LFOMC_P_SPEED) begin
				lfomc_rst_val = `LFOMC_RST_SPEED;
			end else begin
				lfomc_rst_val = `LFOMC_RST_OTHER;
			end
		end
	endfunction

	// Parameter store; patch load wins over a panel edit
	always @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			for (i = 0; i < 2 * `LFOMC_SLOTS; i = i + 1) begin
				par_mem[i] <= lfomc_rst_val(i[3:0]);
			end
		end else if (patch_we_in && patch_addr_in < `LFOMC_NPAR) begin
			par_mem[{patch_lfo_in, patch_addr_in}] <= patch_data_in;
		end else if (edit_we_in && edit_addr_in < `LFOMC_NPAR) begin
			par_mem[{lfo_sel_in, edit_addr_in}] <= edit_data_in;
		end
	end

	// Patch dump port
	always @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			patch_rd_data_out <= 8'h00;
		end else if (patch_rd_addr_in < `LFOMC_NPAR) begin
			patch_rd_data_out <= par_mem[{patch_rd_lfo_in, patch_rd_addr_in}];
		end else begin
			patch_rd_data_out <= 8'h00;
		end
	end

	// Held key count
	always @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			held_reg <= 7'h00;
		end else if (key_on_in && !key_off_in && held_reg != 7'h7F) begin
			held_reg <= held_reg + 7'h01;
		end else if (key_off_in && !key_on_in && held_reg != 7'h00) begin
			held_reg <= held_reg - 7'h01;
		end
	end

	assign held_keys_out = held_reg;
	assign restart_any = key_on_in;
	assign restart_first = key_on_in && (held_reg == 7'h00);
	assign lfo1_out = lfo_all[9:0];
	assign lfo2_out = lfo_all[19:10];

	genvar l;
	generate
		for (l = 0; l < 2; l = l + 1) begin : g_lfo
			wire [7:0] slew_p = par_mem[l*`LFOMC_SLOTS + `LFOMC_P_SLEW];
			wire [7:0] env_p = par_mem[l*`LFOMC_SLOTS + `LFOMC_P_ENV3];
			wire [7:0] whl_p = par_mem[l*`LFOMC_SLOTS + `LFOMC_P_WHEEL];
			wire [7:0] prs_p = par_mem[l*`LFOMC_SLOTS + `LFOMC_P_PRESS];
			wire [7:0] rsync_p = par_mem[l*`LFOMC_SLOTS + `LFOMC_P_RSYNC];
			wire [7:0] dmode_p = par_mem[l*`LFOMC_SLOTS + `LFOMC_P_DMODE];
			wire [7:0] ddir_p = par_mem[l*`LFOMC_SLOTS + `LFOMC_P_DDIR];
			wire [7:0] dsync_p = par_mem[l*`LFOMC_SLOTS + `LFOMC_P_DSYNC];
			wire [7:0] dtrig_p = par_mem[l*`LFOMC_SLOTS + `LFOMC_P_DTRIG];
			wire [7:0] ksync_p = par_mem[l*`LFOMC_SLOTS + `LFOMC_P_KSYNC];
			wire [7:0] spd_p = par_mem[l*`LFOMC_SLOTS + `LFOMC_P_SPEED];
			wire [7:0] dly_p = par_mem[l*`LFOMC_SLOTS + `LFOMC_P_DELAY];
			wire [7:0] off_p = par_mem[l*`LFOMC_SLOTS + `LFOMC_P_OFFSET];
			wire [7:0] wave_p = par_mem[l*`LFOMC_SLOTS + `LFOMC_P_WAVE];
			reg [6:0] speed_reg;
			reg [6:0] speed_next;
			reg [23:0] phase_reg;
			reg [10:0] tick_reg;
			reg wrap_reg;
			reg [19:0] dcnt_reg;
			reg [8:0] depth;
			wire signed [10:0] spd_sum;
			wire rsync_on;
			wire dsync_on;
			wire [10:0] period;
			wire [24:0] step_full;
			wire [24:0] free_sum;
			wire [23:0] inc;
			wire [19:0] knob_len;
			wire [19:0] dly_len;
			wire dly_step;
			wire dly_done;
			wire restart;
			wire [27:0] frac_full;
			wire [8:0] frac;

			// Speed sum of knob and three modulators
			assign spd_sum = $signed({4'h0, spd_p[6:0]}) + lfomc_mod(env_p, env3_level_in) +
				lfomc_mod(whl_p, wheel_in) + lfomc_mod(prs_p, pressure_in);

			// Clamp to the valid speed range
			always @* begin
				if (spd_sum < 0) begin
					speed_next = 7'h00;
				end else if (spd_sum > $signed({4'h0, `LFOMC_SPEED_MAX})) begin
					speed_next = `LFOMC_SPEED_MAX;
				end else begin
					speed_next = spd_sum[6:0];
				end
			end

			// Rate sync selection and per-tick step
			assign rsync_on = rsync_p != 8'h00 && rsync_p <= `LFOMC_NDIV;
			assign period = lfomc_ticks(rsync_p);
			assign step_full = 25'h1000000 / {14'h0000, period};
			assign inc = {17'h00000, speed_reg} << INC_SHIFT;
			assign free_sum = {1'b0, phase_reg} + {1'b0, inc};

			// Speed register and phase accumulator
			always @(posedge clk_sys_in or posedge rst_in) begin
				if (rst_in) begin
					speed_reg <= 7'h00;
					phase_reg <= 24'h000000;
					tick_reg <= 11'h000;
					wrap_reg <= 1'b0;
				end else begin
					speed_reg <= speed_next;
					wrap_reg <= 1'b0;
					if (ksync_p[0] && key_on_in) begin
						phase_reg <= 24'h000000;
						tick_reg <= 11'h000;
						wrap_reg <= 1'b1;
					end else if (rsync_on) begin
						if (midi_tick_in) begin
							if (tick_reg + 11'h001 >= period) begin
								phase_reg <= 24'h000000;
								tick_reg <= 11'h000;
								wrap_reg <= 1'b1;
							end else begin
								phase_reg <= phase_reg + step_full[23:0];
								tick_reg <= tick_reg + 11'h001;
							end
						end
					end else if (sample_tick_in) begin
						phase_reg <= free_sum[23:0];
						wrap_reg <= free_sum[24];
					end
				end
			end

			// Delay length source and trigger policy
			assign dsync_on = dsync_p != 8'h00 && dsync_p <= `LFOMC_NDIV;
			assign knob_len = {13'h0000, dly_p[6:0]} * {8'h00, DLY_UNIT};
			assign dly_len = dsync_on ? {9'h000, lfomc_ticks(dsync_p)} : knob_len;
			assign dly_step = dsync_on ? midi_tick_in : sample_tick_in;
			assign dly_done = dcnt_reg >= dly_len;
			assign restart = dtrig_p[0] ? restart_first : restart_any;

			// Delay timer
			always @(posedge clk_sys_in or posedge rst_in) begin
				if (rst_in) begin
					dcnt_reg <= 20'h00000;
				end else if (restart) begin
					dcnt_reg <= 20'h00000;
				end else if (dly_step && !dly_done) begin
					dcnt_reg <= dcnt_reg + 20'h00001;
				end
			end

			// Depth envelope from delay progress
			assign frac_full = {dcnt_reg, 8'h00} / {8'h00, dly_len};
			assign frac = dly_done ? `LFOMC_FULL_DEPTH : frac_full[8:0];
			always @* begin
				if (dly_len == 20'h00000) begin
					depth = `LFOMC_FULL_DEPTH;
				end else if (!dmode_p[0]) begin
					depth = ddir_p[0] ? `LFOMC_FULL_DEPTH - frac : frac;
				end else if (ddir_p[0]) begin
					depth = dly_done ? 9'h000 : `LFOMC_FULL_DEPTH;
				end else begin
					depth = dly_done ? `LFOMC_FULL_DEPTH : 9'h000;
				end
			end

			assign delay_busy_out[l] = !dly_done;
			assign speed_out[l*7+6:l*7] = speed_reg;

			// Waveform, depth, offset and slew
			lfomc_core u_core (
				.clk_sys_in(clk_sys_in),
				.rst_in(rst_in),
				.sample_tick_in(sample_tick_in),
				.wrap_in(wrap_reg),
				.phase_in(phase_reg[23:16]),
				.wave_in(wave_p[1:0]),
				.depth_in(depth),
				.slew_in(slew_p[6:0]),
				.offset_in(off_p[6:0]),
				.lfo_out(lfo_all[l*10+9:l*10])
			);
		end
	endgenerate
endmodule // lfomc_top

/* File: lfomc_checker.sv */
`timescale 1ns/1ps
module lfomc_checker (
	// Clock and reset
	input wire clk_sys_in,
	input wire rst_in,
	// Timing, keys and controllers
	input wire sample_tick_in,
	input wire key_on_in,
	input wire key_off_in,
	input wire [6:0] env3_level_in,
	input wire [6:0] wheel_in,
	input wire [6:0] pressure_in,
	// Store access
	input wire edit_we_in,
	input wire patch_we_in,
	input wire patch_lfo_in,
	input wire [3:0] patch_addr_in,
	input wire [7:0] patch_data_in,
	input wire patch_rd_lfo_in,
	input wire [3:0] patch_rd_addr_in,
	// Design outputs
	input wire [7:0] patch_rd_data_out,
	input wire [6:0] held_keys_out,
	input wire [13:0] speed_out,
	input wire signed [9:0] lfo1_out,
	input wire signed [9:0] lfo2_out
);
	default clocking cb @(posedge clk_sys_in);
	endclocking
	default disable iff (rst_in);
	// LFO outputs only move on sample ticks
	a_out_hold: assert property (!sample_tick_in |=> $stable(lfo1_out) && $stable(lfo2_out))
		else $error("lfo output moved without tick");
	// Reset state and first speed value
	a_reset_state: assert property ($fell(rst_in) |-> lfo1_out == 0 && held_keys_out == 0
		##1 speed_out == 14'h2040) else $error("bad state after reset");
	// Speed only follows store writes and controllers
	a_speed_steady: assert property (!$past(edit_we_in) && !$past(patch_we_in)
		&& !$past(rst_in) && $stable(env3_level_in) && $stable(wheel_in) && $stable(pressure_in)
		|=> $stable(speed_out)) else $error("speed moved without cause");
	// Patch dump behaviour
	a_dump_steady: assert property (!$past(edit_we_in) && !$past(patch_we_in)
		&& !$past(rst_in) && $stable(patch_rd_addr_in) && $stable(patch_rd_lfo_in)
		|=> $stable(patch_rd_data_out)) else $error("dump moved without cause");
	a_dump_high: assert property (patch_rd_addr_in > 4'hD |=> patch_rd_data_out == 8'h00)
		else $error("unused slot not zero");
	a_dump_write: assert property (patch_we_in && patch_addr_in < 4'hE ##1
		patch_rd_lfo_in == $past(patch_lfo_in) && patch_rd_addr_in == $past(patch_addr_in)
		|=> patch_rd_data_out == $past(patch_data_in, 2)) else $error("stored value lost");
	// Held key count
	a_held_up: assert property (key_on_in && !key_off_in && held_keys_out != 7'h7F
		|=> held_keys_out == $past(held_keys_out) + 7'h01) else $error("key count not raised");
	a_held_down: assert property (key_off_in && !key_on_in && held_keys_out != 7'h00
		|=> held_keys_out == $past(held_keys_out) - 7'h01) else $error("key count not lowered");
	a_held_same: assert property (key_on_in == key_off_in |=> $stable(held_keys_out))
		else $error("key count moved");
endmodule // lfomc_checker

/* File: lfomc_engine.sv */
`timescale 1ns/1ps
module lfomc_engine #(
	parameter SDIV = 4,
	parameter MDIV = 8
) (
	// Clock and reset
	input wire clk_sys_in,
	input wire rst_in,
	// Key requests from the bench
	input wire press_in,
	input wire lift_in,
	// Timing and key pulses
	output reg sample_tick_out,
	output reg midi_tick_out,
	output reg key_on_out,
	output reg key_off_out
);
	reg [7:0] s_cnt_reg;
	reg [7:0] m_cnt_reg;
	// Free sample and clock tick dividers, key requests registered one cycle late
	always @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			s_cnt_reg <= 8'h00;
			m_cnt_reg <= 8'h00;
			sample_tick_out <= 1'b0;
			midi_tick_out <= 1'b0;
			key_on_out <= 1'b0;
			key_off_out <= 1'b0;
		end else begin
			s_cnt_reg <= (s_cnt_reg == SDIV - 1) ? 8'h00 : s_cnt_reg + 8'h01;
			m_cnt_reg <= (m_cnt_reg == MDIV - 1) ? 8'h00 : m_cnt_reg + 8'h01;
			sample_tick_out <= (s_cnt_reg == SDIV - 1);
			midi_tick_out <= (m_cnt_reg == MDIV - 1);
			key_on_out <= press_in;
			key_off_out <= lift_in;
		end
	end
endmodule // lfomc_engine

/* File: tb_lfo_modulation_control.sv */
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared = n_compared + 1; if ((a) !== (b)) begin \
	bad_count = bad_count + 1; $display("wrong value at %0t: %h %h", $time, a, b); end end
module tb_lfo_modulation_control;
	// Bench state
	reg clk_sys_in = 0, rst_in = 1, press = 0, lift = 0, sel = 0, ewe = 0, pwe = 0;
	reg plfo = 0, rlfo = 0, cl = 0;
	reg [3:0] ead = 0, pad = 0, rad = 0;
	reg [7:0] edt = 0, pdt = 0;
	reg [6:0] env3 = 0, wheel = 0, press_lv = 0;
	wire s_tick, m_tick, k_on, k_off;
	wire [7:0] rd_data;
	wire [6:0] held;
	wire [1:0] busy;
	wire [13:0] speed;
	wire signed [9:0] lfo1, lfo2;
	integer seed = 55, bad_count = 0, n_compared = 0, i, j, k, e;
	integer dv [1:3];
	integer cv [1:3];
	reg [7:0] mem [0:31];
	reg signed [9:0] v1;
	// Clock
	always #50 clk_sys_in = ~clk_sys_in;
	lfomc_engine eng (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .press_in(press),
		.lift_in(lift), .sample_tick_out(s_tick), .midi_tick_out(m_tick),
		.key_on_out(k_on), .key_off_out(k_off));
	lfomc_top #(.DLY_UNIT(12'h001)) dut (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
		.sample_tick_in(s_tick), .midi_tick_in(m_tick), .key_on_in(k_on), .key_off_in(k_off),
		.env3_level_in(env3), .wheel_in(wheel), .pressure_in(press_lv), .lfo_sel_in(sel),
		.edit_we_in(ewe), .edit_addr_in(ead), .edit_data_in(edt), .patch_we_in(pwe),
		.patch_lfo_in(plfo), .patch_addr_in(pad), .patch_data_in(pdt), .patch_rd_lfo_in(rlfo),
		.patch_rd_addr_in(rad), .patch_rd_data_out(rd_data), .held_keys_out(held),
		.delay_busy_out(busy), .speed_out(speed), .lfo1_out(lfo1), .lfo2_out(lfo2));
	// Waits land between edges so outputs are settled
	task wt(input integer n);
		repeat (n) @(negedge clk_sys_in);
	endtask
	task wr(input l, input [3:0] a, input [7:0] v);
		begin
			@(posedge clk_sys_in);
			pwe <= 1'b1;
			plfo <= l;
			pad <= a;
			pdt <= v;
			rlfo <= l;
			rad <= a;
			@(posedge clk_sys_in);
			pwe <= 1'b0;
		end
	endtask
	task ed(input l, input [3:0] a, input [7:0] v);
		begin
			@(posedge clk_sys_in);
			ewe <= 1'b1;
			sel <= l;
			ead <= a;
			edt <= v;
			@(posedge clk_sys_in);
			ewe <= 1'b0;
		end
	endtask
	task key(input on, input off);
		begin
			@(posedge clk_sys_in);
			press <= on;
			lift <= off;
			@(posedge clk_sys_in);
			press <= 1'b0;
			lift <= 1'b0;
		end
	endtask
	// Whole setup of the LFO picked by cl, slew and speed depths zero
	task cfg(input integer rs, md, dr, ds, tr, ks, sp, kn, of, wv);
		begin
			for (j = 0; j < 4; j = j + 1)
				wr(cl, j[3:0], 8'h00);
			wr(cl, 4'h4, rs[7:0]);
			wr(cl, 4'h5, md[7:0]);
			wr(cl, 4'h6, dr[7:0]);
			wr(cl, 4'h7, ds[7:0]);
			wr(cl, 4'h8, tr[7:0]);
			wr(cl, 4'h9, ks[7:0]);
			wr(cl, 4'hA, sp[7:0]);
			wr(cl, 4'hB, kn[7:0]);
			wr(cl, 4'hC, of[7:0]);
			wr(cl, 4'hD, wv[7:0]);
		end
	endtask
	function [6:0] exp_speed(input integer kn);
		integer s, m;
		begin
			s = kn;
			for (m = 1; m < 4; m = m + 1)
				s = s + ((dv[m] * cv[m]) >>> 6);
			exp_speed = (s < 0) ? 7'h00 : (s > 127) ? 7'h7F : s[6:0];
		end
	endfunction
	task close_out;
		begin
			if (bad_count == 0 && n_compared > 0)
				$display("Testbench passed");
			else
				$display("Testbench failed");
			$finish;
		end
	endtask
	// Watchdog
	initial begin
		#3000000;
		bad_count = bad_count + 1;
		close_out;
	end
	// Main sequence
	initial begin
		wt(8);
		@(posedge clk_sys_in);
		rst_in <= 1'b0;
		wt(2);
		`CHK(speed, 14'h2040)
		for (i = 0; i < 12; i = i + 1) begin
			k = (i == 0) ? 127 : (i == 1) ? 0 : $random(seed) & 127;
			for (e = 1; e < 4; e = e + 1) begin
				dv[e] = (i == 0) ? 63 : (i == 1) ? -64 : ($random(seed) & 127) - 64;
				cv[e] = (i < 2) ? 127 : $random(seed) & 127;
			end
			@(posedge clk_sys_in);
			env3 <= cv[1];
			wheel <= cv[2];
			press_lv <= cv[3];
			for (e = 1; e < 4; e = e + 1)
				ed(i[0], e[3:0], dv[e][7:0]);
			ed(i[0], 4'hA, k[7:0]);
			wt(3);
			`CHK(i[0] ? speed[13:7] : speed[6:0], exp_speed(k))
		end
		for (i = 0; i < 2; i = i + 1) begin
			cfg(0, 1, i, 0, 0, 1, 0, 20, 0, 2);
			key(1'b1, 1'b0);
			wt(40);
			`CHK(busy[0], 1'b1)
			`CHK(lfo1 != 10'sh000, i[0])
			wt(60);
			`CHK(busy[0], 1'b0)
			`CHK(lfo1 != 10'sh000, !i[0])
		end
		cfg(0, 1, 0, 0, 1, 1, 0, 20, 0, 2);
		key(1'b1, 1'b1);
		key(1'b1, 1'b0);
		wt(4);
		`CHK(busy[0], 1'b0)
		wr(1'b0, 4'h8, 8'h00);
		key(1'b1, 1'b0);
		wt(4);
		`CHK(busy[0], 1'b1)
		repeat (5) key(1'b0, 1'b1);
		wt(2);
		`CHK(held, 7'h00)
		cfg(0, 1, 0, 0, 1, 1, 0, 20, 0, 2);
		// Let the timer expire so only a fresh restart can raise busy
		wt(80);
		`CHK(busy[0], 1'b0)
		key(1'b1, 1'b0);
		wt(4);
		`CHK(busy[0], 1'b1)
		cfg(0, 1, 0, 4, 0, 1, 0, 0, 0, 2);
		key(1'b1, 1'b0);
		wt(20);
		`CHK(busy[0], 1'b1)
		wt(60);
		`CHK(busy[0], 1'b0)
		for (i = 0; i < 2; i = i + 1) begin
			cfg(0, 1, 0, 0, 0, !i[0], 127, 0, 0, 1);
			key(1'b1, 1'b0);
			wt(20);
			v1 = lfo1;
			wt(43);
			key(1'b1, 1'b0);
			wt(20);
			`CHK(lfo1 == v1, !i[0])
		end
		cfg(4, 1, 0, 0, 0, 0, 0, 0, 0, 1);
		// First period starts from a leftover phase, so sample after the first wrap
		wt(56);
		v1 = lfo1;
		wt(24);
		`CHK(lfo1 == v1, 1'b0)
		wt(24);
		`CHK(lfo1, v1)
		for (i = 0; i < 32; i = i + 1) begin
			if (i % 8 == 0)
				cfg(0, 1, 0, 0, 0, 0, 127, 0, 127, i / 8);
			wt(9 + ($random(seed) & 7));
			`CHK(lfo1[9], 1'b0)
		end
		for (i = 0; i < 32; i = i + 1) begin
			mem[i] = (i % 16 > 13) ? 8'h00 : $random(seed);
			wr(i[4], i[3:0], (i % 16 > 13) ? 8'hFF : mem[i]);
		end
		for (i = 0; i < 32; i = i + 1) begin
			@(posedge clk_sys_in);
			rlfo <= i[4];
			rad <= i[3:0];
			wt(2);
			`CHK(rd_data, mem[i])
		end
		// Fade in and out on the second LFO, square held at phase zero
		cl = 1'b1;
		for (i = 0; i < 2; i = i + 1) begin
			cfg(0, 0, i, 0, 0, 1, 0, 20, 0, 2);
			key(1'b1, 1'b0);
			wt(42);
			`CHK(busy[1], 1'b1)
			`CHK(lfo2 > 10'sh000 && lfo2 < 10'sh07F, 1'b1)
			wt(60);
			`CHK(busy[1], 1'b0)
			`CHK(lfo2, i[0] ? 10'sh000 : 10'sh07F)
		end
		close_out;
	end
endmodule // tb_lfo_modulation_control
bind lfomc_top lfomc_checker chk (.clk_sys_in, .rst_in, .sample_tick_in, .key_on_in,
	.key_off_in, .env3_level_in, .wheel_in, .pressure_in, .edit_we_in, .patch_we_in,
	.patch_lfo_in, .patch_addr_in, .patch_data_in, .patch_rd_lfo_in, .patch_rd_addr_in,
	.patch_rd_data_out, .held_keys_out, .speed_out, .lfo1_out, .lfo2_out);
